/* File: hrw_pkg.sv */
/*
 * Package for the hibernation RTC and wake controller: register map, field
 * positions, reset values, timing constants, state encodings and bus carrier.
 * Assumes a 100 MHz system clock and a word-aligned register port.
 */
package hrw_pkg;

	// ----------------------------------------------------------------
	// Bus widths and carrier
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hrw_bus_s;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTL        = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_RTC        = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_MATCH0     = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_MATCH1     = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_TRIM       = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_INT_RAW    = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_INT_MASKED = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_MEM_BASE   = 12'h100;

	// Retained storage: 64 words, selected by address bits 7:2
	localparam int MEM_WORDS = 64;
	localparam int MEM_IDX_W = 6;
	localparam int MEM_IDX_LSB = 2;
	localparam int MEM_SEL_BIT = 8;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTL_MODULE_EN  = 0;
	localparam int CTL_RTC_EN     = 1;
	localparam int CTL_CLK_XTAL   = 2;
	localparam int CTL_WAKE_PIN   = 3;
	localparam int CTL_WAKE_RTC   = 4;
	localparam int CTL_LOWBAT_ABT = 5;
	localparam int CTL_HIB_REQ    = 8;
	localparam int CTL_BAT_START  = 9;
	localparam int CTL_CFG_W      = 6;

	// Status field positions
	localparam int ST_ACTIVE   = 0;
	localparam int ST_BAT_BUSY = 1;
	localparam int ST_HIB_PEND = 2;
	localparam int ST_BAT_LOW  = 3;
	localparam int ST_PWR_OFF  = 4;

	// Interrupt flag positions
	localparam int INT_W       = 4;
	localparam int INT_LOW_BAT = 0;
	localparam int INT_MATCH0  = 1;
	localparam int INT_MATCH1  = 2;
	localparam int INT_WAKE    = 3;

	// ----------------------------------------------------------------
	// Timekeeping
	// ----------------------------------------------------------------
	localparam int                SUB_W       = 15;
	localparam logic [SUB_W-1:0]  SUBSEC_TOP  = 15'h7fff;
	localparam logic [SUB_W-1:0]  TRIM_RESET  = 15'h7fff;
	localparam int                XDIV_W      = 7;
	localparam logic [XDIV_W-1:0] XDIV_LAST   = 7'h7f;
	localparam int                TRIM_SEC_W  = 6;
	localparam logic [TRIM_SEC_W-1:0] TRIM_SEC_HIT = 6'h00;
	localparam int                BPER_W      = 8;
	localparam logic [BPER_W-1:0] BAT_PERIOD_SEC = 8'h3b;

	// Battery check duration
	localparam int CLK_PERIOD_NS = 10;
	localparam int BAT_CHECK_NS  = 1000;
	localparam int BAT_CHECK_CYC = (BAT_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BCNT_W        = 8;

	// ----------------------------------------------------------------
	// State encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HS_RUN = 2'b01,
		HS_HIB = 2'b10
	} hrw_hib_e;

	typedef enum logic [1:0] {
		BS_IDLE  = 2'b01,
		BS_CHECK = 2'b10
	} hrw_bat_e;

endpackage

/* File: hrw_sync3.sv */
/*
 * Three-flop input synchroniser with agreement filter and rising pulse.
 * Assumes an asynchronous pin input and the system clock domain.
 */
module hrw_sync3 (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_clk_en,
	// Pin
	input  wire logic i_pin,
	// Filtered level and edge
	output logic      o_level,
	output logic      o_rise
);

	logic [2:0] sync_ff;
	logic       level_ff;
	wire        agree = (sync_ff[1] == sync_ff[2]);

	// ------------------------------------------------------------
	// Synchroniser; stage 0 feeds only stage 1
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			sync_ff  <= 3'h0;
			level_ff <= 1'b0;
		end else if (i_clk_en) begin
			sync_ff  <= {sync_ff[1:0], i_pin};
			if (agree)
				level_ff <= sync_ff[2];
		end
	end

	assign o_level = level_ff;
	assign o_rise  = agree & sync_ff[2] & ~level_ff;

endmodule

/* File: hrw_match.sv */
/*
 * One RTC match comparator: holds its match value and pulses once when the
 * counter arrives at it. Assumes the register port of the parent block.
 */
module hrw_match
	import hrw_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_nrst,
	input  wire logic              i_clk_en,
	// Software access
	input  wire logic              i_wr,
	input  wire logic [DATA_W-1:0] i_wdata,
	// Counter and arming
	input  wire logic [DATA_W-1:0] i_count,
	input  wire logic              i_arm,
	// Results
	output logic [DATA_W-1:0]      o_match,
	output logic                   o_hit
);

	logic [DATA_W-1:0] match_ff;
	logic              eq_ff;
	wire               eq_now = (i_count == match_ff);

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			match_ff <= '0;
			eq_ff    <= 1'b0;
		end else if (i_clk_en) begin
			if (i_wr)
				match_ff <= i_wdata;
			eq_ff <= eq_now;
		end
	end

	// Only the arrival counts, so a parked counter does not refire
	assign o_match = match_ff;
	assign o_hit   = i_arm & eq_now & ~eq_ff;

endmodule

/* File: hrw_top.sv */
/*
 * Hibernation RTC and wake controller: seconds counter with trim, two match
 * comparators, retained storage, battery checks, wake and power control.
 * Assumes an always-powered supply, a 100 MHz clock and slow clock pins
 * (32.768 kHz oscillator, 4.194304 MHz crystal) sampled as plain inputs.
 */
// Overview of operation
// - A 32-bit seconds counter advances from the hibernation clock while active.
// - A software trim value finely adjusts the counter rate.
// - Two readable, writable match values raise counter events on match.
// - Wake on wake pin, counter match, or either, each separately selectable.
// - Software can read back the selected wake sources.
// - 64 retained 32-bit words, readable and writable by software.
// - Low battery is detected and may abort a pending hibernation request.
// - Each interrupt source is maskable and status is readable.
// - Flags stay set until software clears them; a write clears only the flags whose bits are one.
// - A hibernation request starts removing processor power.
// - An active indication survives processor power cycles.
// - Software can start and stop the counter at any time.
// - Software can read and load the counter value.
// - A forced battery check starts at once.
// - Check-pending reads nonzero during a forced check, zero after.
// - A low check result sets the battery-low flag, interrupting if enabled.
// - Hibernation requests wait while a battery check runs.
// - Clock from the raw oscillator or the crystal divided by 128.
module hrw_top
	import hrw_pkg::*;
(
	// Clock, reset, enable
	input  wire logic      i_clock,
	input  wire logic      i_nrst,
	input  wire logic      i_clk_en,
	// Register port
	input  wire hrw_bus_s  i_bus,
	output logic [DATA_W-1:0] o_rdata,
	// Slow clock and sense pins
	input  wire logic      i_osc_32k,
	input  wire logic      i_xtal,
	input  wire logic      i_wake_pin,
	input  wire logic      i_bat_low,
	// System outputs
	output logic           o_pwr_off,
	output logic           o_irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [CTL_CFG_W-1:0] cfg_ff;
	logic [DATA_W-1:0]    rtc_ff;
	logic [SUB_W-1:0]     sub_ff;
	logic [SUB_W-1:0]     trim_ff;
	logic [XDIV_W-1:0]    xdiv_ff;
	logic [TRIM_SEC_W-1:0] tsec_ff;
	logic [BPER_W-1:0]    bper_ff;
	logic [BCNT_W-1:0]    bcnt_ff;
	logic [INT_W-1:0]     imask_ff;
	logic [INT_W-1:0]     iflag_ff;
	logic                 forced_ff;
	logic                 bat_res_ff;
	logic                 hib_req_ff;
	logic [DATA_W-1:0]    rdata_ff;
	logic                 pwr_off_ff;
	logic                 irq_ff;
	hrw_hib_e             hib_ff;
	hrw_bat_e             bat_ff;
	logic [DATA_W-1:0]    mem [MEM_WORDS];

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic osc_rise, xtal_rise, wake_rise, bat_lvl;

	hrw_sync3 u_sync_osc (
		.i_clock (i_clock), .i_nrst (i_nrst), .i_clk_en (i_clk_en),
		.i_pin   (i_osc_32k), .o_level (), .o_rise (osc_rise)
	);
	hrw_sync3 u_sync_xtal (
		.i_clock (i_clock), .i_nrst (i_nrst), .i_clk_en (i_clk_en),
		.i_pin   (i_xtal), .o_level (), .o_rise (xtal_rise)
	);
	hrw_sync3 u_sync_wake (
		.i_clock (i_clock), .i_nrst (i_nrst), .i_clk_en (i_clk_en),
		.i_pin   (i_wake_pin), .o_level (), .o_rise (wake_rise)
	);
	hrw_sync3 u_sync_bat (
		.i_clock (i_clock), .i_nrst (i_nrst), .i_clk_en (i_clk_en),
		.i_pin   (i_bat_low), .o_level (bat_lvl), .o_rise ()
	);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	wire                 wr       = i_bus.wr;
	wire [ADDR_W-1:0]    addr     = i_bus.addr;
	wire [DATA_W-1:0]    wdata    = i_bus.wdata;
	wire                 mem_sel  = addr[MEM_SEL_BIT] & (addr < (OFS_MEM_BASE << 1));
	wire [MEM_IDX_W-1:0] mem_idx  = addr[MEM_IDX_LSB +: MEM_IDX_W];
	wire                 wr_ctl   = wr & (addr == OFS_CTL);
	wire                 wr_rtc   = wr & (addr == OFS_RTC);
	wire                 wr_m0    = wr & (addr == OFS_MATCH0);
	wire                 wr_m1    = wr & (addr == OFS_MATCH1);
	wire                 wr_trim  = wr & (addr == OFS_TRIM);
	wire                 wr_imask = wr & (addr == OFS_INT_MASK);
	wire                 wr_iclr  = wr & (addr == OFS_INT_RAW);
	wire                 wr_mem   = wr & mem_sel;

	wire mod_en = cfg_ff[CTL_MODULE_EN];
	wire hib_cmd = wr_ctl & wdata[CTL_HIB_REQ] & mod_en;
	wire bat_cmd = wr_ctl & wdata[CTL_BAT_START] & mod_en;

	// ------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------
	// crystal divide by 128
	wire xdiv_wrap = xtal_rise & (xdiv_ff == XDIV_LAST);
	wire slow_tick = cfg_ff[CTL_CLK_XTAL] ? xdiv_wrap : osc_rise;

	wire rtc_run = mod_en & cfg_ff[CTL_RTC_EN];

	// trim replaces the terminal once every 64 seconds
	wire [SUB_W-1:0] sub_last = (tsec_ff == TRIM_SEC_HIT) ? trim_ff : SUBSEC_TOP;
	wire             sec_tick = rtc_run & slow_tick & (sub_ff >= sub_last);

	// ------------------------------------------------------------
	// Match comparators
	// ------------------------------------------------------------
	logic [DATA_W-1:0] m0_val, m1_val;
	logic              m0_hit, m1_hit;

	hrw_match u_match0 (
		.i_clock (i_clock), .i_nrst (i_nrst), .i_clk_en (i_clk_en),
		.i_wr    (wr_m0), .i_wdata (wdata), .i_count (rtc_ff),
		.i_arm   (rtc_run), .o_match (m0_val), .o_hit (m0_hit)
	);
	hrw_match u_match1 (
		.i_clock (i_clock), .i_nrst (i_nrst), .i_clk_en (i_clk_en),
		.i_wr    (wr_m1), .i_wdata (wdata), .i_count (rtc_ff),
		.i_arm   (rtc_run), .o_match (m1_val), .o_hit (m1_hit)
	);

	// ------------------------------------------------------------
	// Battery check and hibernation control
	// ------------------------------------------------------------
	wire bat_busy  = (bat_ff == BS_CHECK);
	wire bat_done  = bat_busy & (bcnt_ff == BCNT_W'(BAT_CHECK_CYC - 1));
	wire bper_due  = sec_tick & (bper_ff == BAT_PERIOD_SEC);
	wire bat_begin = (bat_ff == BS_IDLE) & (bat_cmd | bper_due);
	wire bat_found = bat_done & bat_lvl;

	wire wake_ev = (cfg_ff[CTL_WAKE_PIN] & wake_rise)
		| (cfg_ff[CTL_WAKE_RTC] & (m0_hit | m1_hit));

	wire req_ready = hib_req_ff & (hib_ff == HS_RUN) & ~bat_busy & ~bat_begin;
	wire req_abort = req_ready & cfg_ff[CTL_LOWBAT_ABT] & bat_res_ff;
	wire req_go    = req_ready & ~req_abort;

	wire [INT_W-1:0] iset = {
		(hib_ff == HS_HIB) & wake_ev,
		m1_hit,
		m0_hit,
		bat_found
	};
	// sticky flags, set wins over clear
	wire [INT_W-1:0] iclr       = wr_iclr ? wdata[INT_W-1:0] : '0;
	wire [INT_W-1:0] nxt_iflag  = (iflag_ff & ~iclr) | iset;
	wire [INT_W-1:0] imasked    = iflag_ff & imask_ff;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire [DATA_W-1:0] status_w = DATA_W'({
		pwr_off_ff,
		bat_res_ff,
		hib_req_ff,
		forced_ff & bat_busy,
		mod_en
	});
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (addr)
			OFS_CTL:        rd_mux = DATA_W'(cfg_ff);
			OFS_STATUS:     rd_mux = status_w;
			OFS_RTC:        rd_mux = rtc_ff;
			OFS_MATCH0:     rd_mux = m0_val;
			OFS_MATCH1:     rd_mux = m1_val;
			OFS_TRIM:       rd_mux = DATA_W'(trim_ff);
			OFS_INT_MASK:   rd_mux = DATA_W'(imask_ff);
			OFS_INT_RAW:    rd_mux = DATA_W'(iflag_ff);
			OFS_INT_MASKED: rd_mux = DATA_W'(imasked);
			default:        rd_mux = mem_sel ? mem[mem_idx] : '0;
		endcase
	end

	// ------------------------------------------------------------
	// Configuration and software-visible registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			cfg_ff   <= '0;
			trim_ff  <= TRIM_RESET;
			imask_ff <= '0;
			iflag_ff <= '0;
			rdata_ff <= '0;
			irq_ff   <= 1'b0;
		end else if (i_clk_en) begin
			if (wr_ctl)
				cfg_ff <= wdata[CTL_CFG_W-1:0];
			if (wr_trim)
				trim_ff <= wdata[SUB_W-1:0];
			if (wr_imask)
				imask_ff <= wdata[INT_W-1:0];
			iflag_ff <= nxt_iflag;
			rdata_ff <= i_bus.rd ? rd_mux : '0;
			irq_ff   <= |(nxt_iflag & imask_ff);
		end
	end

	// retained storage; no reset, contents survive processor power loss
	always_ff @(posedge i_clock) begin
		if (i_clk_en && wr_mem)
			mem[mem_idx] <= wdata;
	end

	// ------------------------------------------------------------
	// Seconds counter with trim
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			rtc_ff  <= '0;
			sub_ff  <= '0;
			xdiv_ff <= '0;
			tsec_ff <= '0;
			bper_ff <= '0;
		end else if (i_clk_en) begin
			if (xtal_rise)
				xdiv_ff <= xdiv_ff + XDIV_W'(1);
			if (wr_rtc) begin
				rtc_ff <= wdata;
				sub_ff <= '0;
			end else if (sec_tick) begin
				rtc_ff  <= rtc_ff + DATA_W'(1);
				sub_ff  <= '0;
				tsec_ff <= tsec_ff + TRIM_SEC_W'(1);
			end else if (rtc_run & slow_tick) begin
				sub_ff <= sub_ff + SUB_W'(1);
			end
			if (bper_due)
				bper_ff <= '0;
			else if (sec_tick)
				bper_ff <= bper_ff + BPER_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Battery check sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			bat_ff     <= BS_IDLE;
			bcnt_ff    <= '0;
			forced_ff  <= 1'b0;
			bat_res_ff <= 1'b0;
		end else if (i_clk_en) begin
			case (bat_ff)
				BS_IDLE: begin
					bcnt_ff <= '0;
					if (bat_begin) begin
						bat_ff    <= BS_CHECK;
						forced_ff <= bat_cmd;
					end
				end
				BS_CHECK: begin
					bcnt_ff <= bcnt_ff + BCNT_W'(1);
					if (bat_done) begin
						bat_res_ff <= bat_lvl;
						bat_ff     <= BS_IDLE;
						forced_ff  <= 1'b0;
					end
				end
				default: bat_ff <= BS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Hibernation sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			hib_ff     <= HS_RUN;
			hib_req_ff <= 1'b0;
			pwr_off_ff <= 1'b0;
		end else if (i_clk_en) begin
			// A fresh request wins over the sequencer taking the old one
			hib_req_ff <= hib_cmd | (hib_req_ff & ~req_go & ~req_abort);
			case (hib_ff)
				HS_RUN: begin
					if (req_go) begin
						hib_ff     <= HS_HIB;
						pwr_off_ff <= 1'b1;
					end
				end
				HS_HIB: begin
					if (wake_ev) begin
						hib_ff     <= HS_RUN;
						pwr_off_ff <= 1'b0;
					end
				end
				default: begin
					hib_ff     <= HS_RUN;
					pwr_off_ff <= 1'b0;
				end
			endcase
		end
	end

	assign o_rdata   = rdata_ff;
	assign o_pwr_off = pwr_off_ff;
	assign o_irq     = irq_ff;

endmodule

/* File: hrw_top_checker.sv */
/*
 * Port-level assertions for the hibernation RTC and wake controller.
 * Assumes the register map, field positions and check length of hrw_pkg.
 */
module hrw_top_checker
	import hrw_pkg::*;
(
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_nrst,
	input  wire logic              i_clk_en,
	// Register port
	input  wire hrw_bus_s          i_bus,
	input  wire logic [DATA_W-1:0] o_rdata,
	// Pins
	input  wire logic              i_osc_32k,
	input  wire logic              i_xtal,
	input  wire logic              i_wake_pin,
	input  wire logic              i_bat_low,
	input  wire logic              o_pwr_off,
	input  wire logic              o_irq
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Mirrors of software state
	// ----------------------------------------------------------------
	// Check window padded so a late but legal end never trips the hold check
	localparam logic [7:0] BAT_HOLD = 8'(BAT_CHECK_CYC + 4);
	localparam logic [7:0] BAT_RUN  = 8'(BAT_CHECK_CYC);
	logic                  en_ff;
	logic [INT_W-1:0]      mask_ff;
	logic [7:0]            bat_cnt_ff;
	wire                   rd_take = i_clk_en && i_bus.rd;
	wire                   ctl_wr  = i_clk_en && i_bus.wr && i_bus.addr == OFS_CTL;
	wire                   msk_wr  = i_clk_en && i_bus.wr && i_bus.addr == OFS_INT_MASK;
	wire                   bat_go  = ctl_wr && i_bus.wdata[CTL_BAT_START] && en_ff && bat_cnt_ff == 8'h00;

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			en_ff      <= 1'b0;
			mask_ff    <= '0;
			bat_cnt_ff <= 8'h00;
		end else begin
			if (ctl_wr)
				en_ff <= i_bus.wdata[CTL_MODULE_EN];
			if (msk_wr)
				mask_ff <= i_bus.wdata[INT_W-1:0];
			if (bat_go)
				bat_cnt_ff <= BAT_HOLD;
			else if (bat_cnt_ff != 8'h00 && i_clk_en)
				bat_cnt_ff <= bat_cnt_ff - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	sequence s_hib_req;
		ctl_wr && i_bus.wdata[CTL_HIB_REQ] && !i_bus.wdata[CTL_LOWBAT_ABT] && en_ff
			&& bat_cnt_ff == 8'h00 && !o_pwr_off && !i_bus.wdata[CTL_BAT_START];
	endsequence
	sequence s_enter;
		##1 !o_pwr_off ##1 o_pwr_off;
	endsequence

	a_rdata_idle_zero: assert property ($past(i_clk_en) && !$past(i_bus.rd) |-> o_rdata == '0)
		else $error("read data not zero outside a read answer");
	a_reset_quiet: assert property ($rose(i_nrst) |-> !o_pwr_off && !o_irq && o_rdata == '0)
		else $error("outputs not quiet after reset");
	a_unmapped_zero: assert property ($past(rd_take && i_bus.addr > OFS_INT_MASKED && i_bus.addr < OFS_MEM_BASE)
		|-> o_rdata == '0)
		else $error("unmapped read not zero");
	a_ctl_narrow: assert property ($past(rd_take && i_bus.addr == OFS_CTL) |-> o_rdata[DATA_W-1:CTL_CFG_W] == '0)
		else $error("control readback has upper bits set");
	a_trim_narrow: assert property ($past(rd_take && i_bus.addr == OFS_TRIM) |-> o_rdata[DATA_W-1:SUB_W] == '0)
		else $error("trim readback wider than trim");
	a_status_mirror: assert property ($past(rd_take && i_bus.addr == OFS_STATUS)
		|-> o_rdata[ST_ACTIVE] == $past(en_ff) && o_rdata[ST_PWR_OFF] == $past(o_pwr_off))
		else $error("status active or power bit wrong");
	// Line and read data agree one cycle apart, and only while the mask held
	a_irq_tracks: assert property ($past(rd_take && i_bus.addr == OFS_INT_MASKED)
		&& $past(mask_ff) == $past(mask_ff, 2)
		|-> $past(o_irq) == (o_rdata != '0) && o_rdata[DATA_W-1:INT_W] == '0)
		else $error("interrupt line disagrees with masked status");
	a_irq_masked: assert property (mask_ff == '0 && $past(mask_ff) == '0 |-> !o_irq)
		else $error("interrupt raised with all sources masked");
	a_hib_enter: assert property (s_hib_req |-> s_enter)
		else $error("hibernation not entered two cycles after request");
	a_check_holds: assert property (bat_cnt_ff > 8'h04 && bat_cnt_ff < BAT_RUN |-> !$rose(o_pwr_off))
		else $error("power removed during a battery check");
endmodule

bind hrw_top hrw_top_checker hrw_top_checker_inst (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_osc_32k(i_osc_32k), .i_xtal(i_xtal), .i_wake_pin(i_wake_pin), .i_bat_low(i_bat_low),
	.o_pwr_off(o_pwr_off), .o_irq(o_irq)
);

/* File: hrw_far_model.sv */
/*
 * Far side of the controller: slow clock sources, wake pin, battery sense.
 * Assumes the bench clock; slow clocks run sped up to keep runs short.
 */
module hrw_far_model (
	// Clock and controls
	input  wire logic i_clock,
	input  wire logic i_wake_req,
	input  wire logic i_bat_weak,
	// Pins towards the block
	output logic      o_osc_32k,
	output logic      o_xtal,
	output logic      o_wake_pin,
	output logic      o_bat_low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_ff      = 2'h0;
	logic       osc_ff      = 1'b0;
	logic       xtal_ff     = 1'b0;
	logic [3:0] wake_cnt_ff = 4'h0;
	logic       bat_ff      = 1'b0;

	// Oscillators run free; wake pin is a pulse long enough to pass the filter
	always @(posedge i_clock) begin
		div_ff  <= div_ff + 2'h1;
		// Crystal level held two clocks, or the pin filter never sees agreement
		if (div_ff[0])
			xtal_ff <= ~xtal_ff;
		if (div_ff == 2'h3)
			osc_ff <= ~osc_ff;
		if (i_wake_req)
			wake_cnt_ff <= 4'h8;
		else if (wake_cnt_ff != 4'h0)
			wake_cnt_ff <= wake_cnt_ff - 4'h1;
		bat_ff <= i_bat_weak;
	end
	assign o_osc_32k  = osc_ff;
	assign o_xtal     = xtal_ff;
	assign o_wake_pin = wake_cnt_ff != 4'h0;
	assign o_bat_low  = bat_ff;
endmodule

/* File: tb_hrw_top.sv */
/*
 * Self-checking bench for the hibernation RTC and wake controller.
 * Assumes hrw_pkg, the far-side model and the bound checker.
 */
module tb_hrw_top
	import hrw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              i_clock;
	logic              i_nrst;
	logic              i_clk_en;
	logic              wake_req;
	logic              bat_weak;
	logic              osc;
	logic              xtal;
	logic              wake_pin;
	logic              bat_low;
	logic              o_pwr_off;
	logic              o_irq;
	logic [DATA_W-1:0] o_rdata;
	hrw_bus_s          i_bus;
	int                errors;
	int                cmp_count;

	hrw_top hrw_top_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_bus(i_bus),
		.o_rdata(o_rdata), .i_osc_32k(osc), .i_xtal(xtal), .i_wake_pin(wake_pin), .i_bat_low(bat_low),
		.o_pwr_off(o_pwr_off), .o_irq(o_irq));
	hrw_far_model hrw_far_model_inst (.i_clock(i_clock), .i_wake_req(wake_req), .i_bat_weak(bat_weak),
		.o_osc_32k(osc), .o_xtal(xtal), .o_wake_pin(wake_pin), .o_bat_low(bat_low));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clock);
		i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clock);
		i_bus <= '0;
	endtask
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Read data stand only in the cycle after the strobe is taken
	task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge i_clock);
		i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
		@(posedge i_clock);
		i_bus <= '0;
		#1;
		check(o_rdata, exp);
	endtask
	task automatic wait_pwr(input logic v);
		int n;
		n = 0;
		while (o_pwr_off !== v && n < 400) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		check(32'(o_pwr_off), 32'(v));
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic pulse_wake();
		@(posedge i_clock) wake_req <= 1'b1;
		@(posedge i_clock) wake_req <= 1'b0;
	endtask
	task automatic test_done();
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// Whole run is near 900 cycles; far beyond that means a hang
	initial begin
		repeat (6000) @(posedge i_clock);
		errors++;
		test_done();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		i_nrst = 1'b0;
		i_clk_en = 1'b1;
		i_bus = '0;
		wake_req = 1'b0;
		bat_weak = 1'b0;
		errors = 0;
		cmp_count = 0;
		repeat (8) @(posedge i_clock);
		i_nrst <= 1'b1;
		chk(OFS_TRIM, 32'h0000_7fff);
		chk(OFS_CTL, 32'h0000_0000);
		chk(OFS_STATUS, 32'h0000_0000);
		chk(OFS_INT_RAW, 32'h0000_0000);
		chk(12'h080, 32'h0000_0000);
		reg_wr(OFS_CTL, 32'h0000_0001);
		reg_wr(OFS_CTL, 32'h0000_0005);
		idle(64);
		chk(OFS_CTL, 32'h0000_0005);
		chk(OFS_STATUS, 32'h0000_0001);
		reg_wr(OFS_TRIM, 32'h0000_7abc);
		chk(OFS_TRIM, 32'h0000_7abc);
		reg_wr(OFS_CTL, 32'h0000_000d);
		reg_wr(OFS_RTC, 32'h0000_0000);
		chk(OFS_INT_RAW, 32'h0000_0000);
		reg_wr(OFS_RTC, 32'hffff_fffe);
		chk(OFS_RTC, 32'hffff_fffe);
		reg_wr(OFS_MATCH0, 32'h1234_5678);
		reg_wr(OFS_MATCH1, 32'ha5a5_0001);
		chk(OFS_MATCH0, 32'h1234_5678);
		chk(OFS_MATCH1, 32'ha5a5_0001);
		reg_wr(OFS_CTL, 32'h0000_000f);
		reg_wr(OFS_RTC, 32'h1234_5678);
		chk(OFS_RTC, 32'h1234_5678);
		chk(OFS_INT_RAW, 32'h0000_0002);
		idle(20);
		chk(OFS_INT_RAW, 32'h0000_0002);
		reg_wr(OFS_INT_RAW, 32'h0000_0002);
		chk(OFS_INT_RAW, 32'h0000_0000);
		reg_wr(OFS_RTC, 32'ha5a5_0001);
		chk(OFS_INT_RAW, 32'h0000_0004);
		reg_wr(OFS_INT_RAW, 32'h0000_0004);
		for (int i = 0; i < MEM_WORDS; i++)
			reg_wr(OFS_MEM_BASE + 12'(i * 4), {8'(i), 8'hc3, 8'(~i), 8'h5a});
		// Forced check with a weak battery
		reg_wr(OFS_INT_MASK, 32'h0000_0001);
		chk(OFS_INT_MASK, 32'h0000_0001);
		@(posedge i_clock) bat_weak <= 1'b1;
		idle(8);
		reg_wr(OFS_CTL, 32'h0000_020f);
		chk(OFS_STATUS, 32'h0000_0003);
		idle(120);
		chk(OFS_STATUS, 32'h0000_0009);
		chk(OFS_INT_RAW, 32'h0000_0001);
		check(32'(o_irq), 32'h0000_0001);
		chk(OFS_INT_MASKED, 32'h0000_0001);
		reg_wr(OFS_INT_MASK, 32'h0000_0000);
		idle(2);
		check(32'(o_irq), 32'h0000_0000);
		chk(OFS_INT_RAW, 32'h0000_0001);
		reg_wr(OFS_INT_RAW, 32'h0000_0001);
		// Low battery drops the request
		reg_wr(OFS_CTL, 32'h0000_002f);
		reg_wr(OFS_CTL, 32'h0000_012f);
		idle(10);
		check(32'(o_pwr_off), 32'h0000_0000);
		chk(OFS_STATUS, 32'h0000_0009);
		// Request waits for a running check
		@(posedge i_clock) bat_weak <= 1'b0;
		idle(8);
		reg_wr(OFS_CTL, 32'h0000_020f);
		reg_wr(OFS_CTL, 32'h0000_010f);
		chk(OFS_STATUS, 32'h0000_000f);
		check(32'(o_pwr_off), 32'h0000_0000);
		wait_pwr(1'b1);
		// Match with counter wake off keeps sleeping; pin wakes
		reg_wr(OFS_RTC, 32'h1234_5678);
		idle(10);
		check(32'(o_pwr_off), 32'h0000_0001);
		pulse_wake();
		wait_pwr(1'b0);
		chk(OFS_INT_RAW, 32'h0000_000a);
		chk(OFS_STATUS, 32'h0000_0001);
		for (int i = 0; i < MEM_WORDS; i++)
			chk(OFS_MEM_BASE + 12'(i * 4), {8'(i), 8'hc3, 8'(~i), 8'h5a});
		reg_wr(OFS_INT_RAW, 32'h0000_000f);
		// Counter match as the only wake source
		reg_wr(OFS_CTL, 32'h0000_0017);
		chk(OFS_CTL, 32'h0000_0017);
		reg_wr(OFS_CTL, 32'h0000_0117);
		wait_pwr(1'b1);
		pulse_wake();
		idle(12);
		check(32'(o_pwr_off), 32'h0000_0001);
		reg_wr(OFS_RTC, 32'ha5a5_0001);
		wait_pwr(1'b0);
		chk(OFS_INT_RAW, 32'h0000_000c);
		// Trim is the terminal of the first second; divided crystal is far too slow here
		reg_wr(OFS_TRIM, 32'h0000_0003);
		reg_wr(OFS_RTC, 32'h0000_0010);
		idle(60);
		chk(OFS_RTC, 32'h0000_0010);
		reg_wr(OFS_CTL, 32'h0000_0003);
		idle(60);
		chk(OFS_RTC, 32'h0000_0011);
		test_done();
	end
endmodule
